// ---- ifeb_regs.vh ----
// Purpose: register map and field positions of the interrupt flag/enable bank
// Assumes: classic wishbone, 32-bit data, word aligned offsets
// Notes:   flags sit in bits 7..4 of each control register, enables in bits 3..0
`ifndef IFEB_REGS_VH
`define IFEB_REGS_VH

// register byte offsets
`define IFEB_OFF_CMP_ADC_T0      4'h0
`define IFEB_OFF_EE_TMR_LV       4'h4
`define IFEB_OFF_TW_PULSE        4'h8
`define IFEB_OFF_GLOBAL          4'hC
`define IFEB_OFF_STATUS          5'h10
`define IFEB_OFF_MASK            5'h14
`define IFEB_ADDR_W              5

// control register reset value
`define IFEB_CTRL_RST            8'h00

// flag and enable nibbles
`define IFEB_FLAG_HI             7
`define IFEB_FLAG_LO             4
`define IFEB_EN_HI               3
`define IFEB_EN_LO               0

// bit positions inside the first register
`define IFEB_B_CMP3_FLAG         7
`define IFEB_B_CMP2_FLAG         6
`define IFEB_B_ADC_FLAG          5
`define IFEB_B_T0_FLAG           4
`define IFEB_B_CMP3_EN           3
`define IFEB_B_CMP2_EN           2
`define IFEB_B_ADC_EN            1
`define IFEB_B_T0_EN             0

// bit positions inside the second register
`define IFEB_B_EE_FLAG           7
`define IFEB_B_T2_FLAG           6
`define IFEB_B_T1_FLAG           5
`define IFEB_B_LV_FLAG           4
`define IFEB_B_EE_EN             3
`define IFEB_B_T2_EN             2
`define IFEB_B_T1_EN             1
`define IFEB_B_LV_EN             0

// global register and event status bits
`define IFEB_B_GIE               0
`define IFEB_EV_SERVICE          0
`define IFEB_EV_PENDING_MASKED   1
`define IFEB_EV_W                2

`endif

// ---- ifeb_ctrl_reg.v ----
// Purpose: one 8-bit control register, four request flags above four enables
// Assumes: single clock, synchronous active high reset
// Notes:   hardware set beats software write, service clear acts on flags only
`timescale 1ns/1ps
`default_nettype none
`include "ifeb_regs.vh"

module ifeb_ctrl_reg
(
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       wr_i,
    input  wire [7:0] wdata_i,
    input  wire [3:0] set_i,
    input  wire [3:0] svc_clr_i,
    output wire [7:0] value_o,
    output wire [3:0] req_o
);

    reg  [7:0] reg_ff;
    reg  [7:0] nxt_reg;

    // next value: software write, then service clear, then hardware set
    always @*
    begin
        nxt_reg = reg_ff;
        if (wr_i)
        begin
            nxt_reg = wdata_i;
        end
        nxt_reg[`IFEB_FLAG_HI:`IFEB_FLAG_LO] = nxt_reg[`IFEB_FLAG_HI:`IFEB_FLAG_LO]
                                               & ~svc_clr_i;
        nxt_reg[`IFEB_FLAG_HI:`IFEB_FLAG_LO] = nxt_reg[`IFEB_FLAG_HI:`IFEB_FLAG_LO]
                                               | set_i;
    end

    // storage, cleared at reset
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reg_ff <= `IFEB_CTRL_RST;
        end
        else
        begin
            reg_ff <= nxt_reg;
        end
    end

    // a flag requests only when its own enable is set
    assign value_o = reg_ff;
    assign req_o   = reg_ff[`IFEB_FLAG_HI:`IFEB_FLAG_LO]
                     & reg_ff[`IFEB_EN_HI:`IFEB_EN_LO];

endmodule
`default_nettype wire

// ---- ifeb_bank.v ----
// Purpose: interrupt request flags and enables for twelve peripheral sources
// Assumes: classic wishbone slave, one clock, synchronous active high reset
// Notes:   picks the highest priority pending source and hands it to the core
`timescale 1ns/1ps
`default_nettype none
`include "ifeb_regs.vh"

// Functional notes
// - eeprom request flag is bit 7 of second register, 1 means pending.
// - low voltage request flag is bit 4 of second register.
// - low voltage enable is bit 0 of second register.
// - conversion done enable is bit 1 of first register.
// - timer zero enable is bit 0 of first register.
// - timer two enable is bit 2 of second register.
// - timer one enable is bit 1 of second register.
// - a set flag interrupts only when its enable is 1, else stays recorded.
// - global enable low blocks all; servicing clears global enable automatically; here it blocks core_irq_o only, irq_o can still fire.
module ifeb_bank
(
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [4:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    // peripheral event pulses
    input  wire        comparator_three_evt_i,
    input  wire        comparator_two_evt_i,
    input  wire        conversion_done_evt_i,
    input  wire        timer_zero_evt_i,
    input  wire        eeprom_evt_i,
    input  wire        timer_two_evt_i,
    input  wire        timer_one_evt_i,
    input  wire        low_voltage_detector_evt_i,
    input  wire        twowire_evt_i,
    input  wire        pulse_retrigger_evt_i,
    input  wire        pulse_autocount_evt_i,
    input  wire        pulse_timer_evt_i,
    // core service handshake
    input  wire        core_take_i,
    output wire        core_irq_o,
    output wire [3:0]  core_src_o,
    output wire        irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    reg  [31:0] dat_ff;
    reg         ack_ff;
    reg         global_irq_enable_ff;
    reg  [1:0]  status_ff;
    reg  [1:0]  mask_ff;
    reg         irq_ff;
    reg         core_irq_ff;
    reg  [3:0]  core_src_ff;
    reg  [3:0]  nxt_src;
    reg         nxt_any;
    reg  [31:0] nxt_dat;
    reg  [1:0]  nxt_status;
    reg  [11:0] svc_vec;

    wire        bus_req;
    wire        wr_hit;
    wire        lane0_wr;
    wire        wr_c1;
    wire        wr_c2;
    wire        wr_c3;
    wire        take_ok;
    wire [7:0]  c1_val;
    wire [7:0]  c2_val;
    wire [7:0]  c3_val;
    wire [3:0]  c1_req;
    wire [3:0]  c2_req;
    wire [3:0]  c3_req;
    wire [11:0] req_all;

    // a request is answered once, ack drops the cycle after
    assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr_hit   = bus_req & wb_we_i;
    assign lane0_wr = wr_hit & wb_sel_i[0];
    assign wr_c1    = lane0_wr & (wb_adr_i == {1'b0, `IFEB_OFF_CMP_ADC_T0});
    assign wr_c2    = lane0_wr & (wb_adr_i == {1'b0, `IFEB_OFF_EE_TMR_LV});
    assign wr_c3    = lane0_wr & (wb_adr_i == {1'b0, `IFEB_OFF_TW_PULSE});

    ////////////////////////////////////////////////////////////////////////////
    // priority: lower index wins, order follows the vector table

    function [3:0] first_set;
        input [11:0] v;
        integer      k;
        begin
            first_set = 4'hF;
            for (k = 11; k >= 0; k = k - 1)
            begin
                if (v[k])
                begin
                    first_set = k[3:0];
                end
            end
        end
    endfunction

    // core takes the vector only while a request is presented
    assign take_ok = core_take_i & core_irq_ff;

    // one-hot service clear for the selected source
    always @*
    begin
        svc_vec = 12'h000;
        if (take_ok)
        begin
            svc_vec[core_src_ff] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers: flags bits 7..4, enables bits 3..0

    // first: cmp3, cmp2, adc, timer0 (enables adc bit1, timer0 bit0)
    ifeb_ctrl_reg u_cmp_adc_t0
    (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_i      (wr_c1),
        .wdata_i   (wb_dat_i[7:0]),
        .set_i     ({comparator_three_evt_i, comparator_two_evt_i,
                     conversion_done_evt_i, timer_zero_evt_i}),
        .svc_clr_i ({svc_vec[3], svc_vec[2], svc_vec[1], svc_vec[0]}),
        .value_o   (c1_val),
        .req_o     (c1_req)
    );

    // second: eeprom timer2, timer1, low voltage enables
    ifeb_ctrl_reg u_ee_tmr_lv
    (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_i      (wr_c2),
        .wdata_i   (wb_dat_i[7:0]),
        .set_i     ({eeprom_evt_i, timer_two_evt_i,
                     timer_one_evt_i, low_voltage_detector_evt_i}),
        .svc_clr_i ({svc_vec[7], svc_vec[6], svc_vec[5], svc_vec[4]}),
        .value_o   (c2_val),
        .req_o     (c2_req)
    );

    // third: twowire, pulse retrigger, autocount, timer
    ifeb_ctrl_reg u_tw_pulse
    (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_i      (wr_c3),
        .wdata_i   (wb_dat_i[7:0]),
        .set_i     ({twowire_evt_i, pulse_retrigger_evt_i,
                     pulse_autocount_evt_i, pulse_timer_evt_i}),
        .svc_clr_i ({svc_vec[11], svc_vec[10], svc_vec[9], svc_vec[8]}),
        .value_o   (c3_val),
        .req_o     (c3_req)
    );

    // sources in vector order: t0, adc, cmp2, cmp3, lv, t1, t2, ee, ptm, pac, prn, tw
    assign req_all = {c3_req[3], c3_req[2], c3_req[1], c3_req[0],
                      c2_req[3], c2_req[2], c2_req[1], c2_req[0],
                      c1_req[3], c1_req[2], c1_req[1], c1_req[0]};

    ////////////////////////////////////////////////////////////////////////////
    // request presented to core, gated by global enable

    always @*
    begin
        nxt_src = first_set(req_all);
        nxt_any = global_irq_enable_ff & (|req_all) & ~take_ok;
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            core_irq_ff <= 1'b0;
            core_src_ff <= 4'h0;
        end
        else
        begin
            core_irq_ff <= nxt_any;
            core_src_ff <= nxt_src;
        end
    end

    // global enable: software write, auto clear on service wins
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            global_irq_enable_ff <= 1'b0;
        end
        else if (take_ok)
        begin
            global_irq_enable_ff <= 1'b0;
        end
        else if (lane0_wr & (wb_adr_i == {1'b0, `IFEB_OFF_GLOBAL}))
        begin
            global_irq_enable_ff <= wb_dat_i[`IFEB_B_GIE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event status (write one clears, set wins), mask and interrupt line

    always @*
    begin
        nxt_status = status_ff;
        if (lane0_wr & (wb_adr_i == `IFEB_OFF_STATUS))
        begin
            nxt_status = nxt_status & ~wb_dat_i[1:0];
        end
        if (take_ok)
        begin
            nxt_status[`IFEB_EV_SERVICE] = 1'b1;
        end
        if ((|req_all) & ~global_irq_enable_ff)
        begin
            nxt_status[`IFEB_EV_PENDING_MASKED] = 1'b1;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            status_ff <= 2'h0;
            mask_ff   <= 2'h0;
            irq_ff    <= 1'b0;
        end
        else
        begin
            status_ff <= nxt_status;
            if (lane0_wr & (wb_adr_i == `IFEB_OFF_MASK))
            begin
                mask_ff <= wb_dat_i[1:0];
            end
            irq_ff <= |(nxt_status & mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux and acknowledge

    always @*
    begin
        case (wb_adr_i)
            {1'b0, `IFEB_OFF_CMP_ADC_T0}: nxt_dat = {24'h000000, c1_val};
            {1'b0, `IFEB_OFF_EE_TMR_LV}:  nxt_dat = {24'h000000, c2_val};
            {1'b0, `IFEB_OFF_TW_PULSE}:   nxt_dat = {24'h000000, c3_val};
            {1'b0, `IFEB_OFF_GLOBAL}:     nxt_dat = {31'h00000000, global_irq_enable_ff};
            `IFEB_OFF_STATUS:             nxt_dat = {30'h00000000, status_ff};
            `IFEB_OFF_MASK:               nxt_dat = {30'h00000000, mask_ff};
            default:                      nxt_dat = 32'h00000000;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
        end
        else
        begin
            ack_ff <= bus_req;
            dat_ff <= nxt_dat;
        end
    end

    assign wb_ack_o   = ack_ff;
    assign wb_dat_o   = dat_ff;
    assign core_irq_o = core_irq_ff;
    assign core_src_o = core_src_ff;
    assign irq_o      = irq_ff;

endmodule
`default_nettype wire

// ---- ifeb_bank_monitor.sv ----
// Purpose: bus and interrupt timing checks on the bank ports
// Assumes: one clock, synchronous active high reset
// Notes:   bound into every ifeb_bank instance
`timescale 1ns/1ps
`default_nettype none
module ifeb_bank_monitor
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [4:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        core_take_i,
    input wire logic        core_irq_o,
    input wire logic [3:0]  core_src_o,
    input wire logic        irq_o
);
////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // a request taken by the slave
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // write of zero into the global enable
    sequence s_glob_off;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 5'h0C && !wb_dat_i[0];
    endsequence
    AST_ACK_NEXT: assert property (s_req |=> wb_ack_o) else $error("ack late");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper");
    AST_HOLE: assert property (s_req ##0 (!wb_we_i && wb_adr_i == 5'h18) |=> wb_dat_o == 32'h0) else $error("hole");
    AST_RST_QUIET: assert property ($fell(rst_i) |-> !core_irq_o && !irq_o && !wb_ack_o) else $error("reset");
    AST_TAKE_DROP: assert property (core_irq_o && core_take_i |=> !core_irq_o) else $error("take");
    AST_GLOBAL_OFF: assert property (s_glob_off |=> !core_irq_o) else $error("global off");
    AST_SRC_RANGE: assert property (core_irq_o |-> core_src_o < 4'hC) else $error("source");
endmodule
bind ifeb_bank ifeb_bank_monitor mon_u
(
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_take_i(core_take_i),
    .core_irq_o(core_irq_o), .core_src_o(core_src_o), .irq_o(irq_o)
);
`default_nettype wire

// ---- ifeb_core_model.sv ----
// Purpose: processor core that accepts presented vectors
// Assumes: one clock, synchronous active high reset
// Notes:   answer delay set per vector, zero to three cycles
`timescale 1ns/1ps
`default_nettype none
module ifeb_core_model
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       irq_i,
    input wire logic [1:0] delay_i,
    output var logic       take_o
);
////////////////////////////////////////////////////////////////////////////////
    logic [1:0] cnt_ff;
    // one-cycle take pulse only while a vector is presented
    always @(posedge clk_i)
    begin
        if (rst_i || !irq_i || take_o)
        begin
            cnt_ff <= 2'h0;
            take_o <= 1'b0;
        end
        else if (cnt_ff == delay_i)
            take_o <= 1'b1;
        else
            cnt_ff <= cnt_ff + 2'h1;
    end
endmodule
`default_nettype wire

// ---- ifeb_bank_tb_top.sv ----
// Purpose: self-checking bench for the interrupt flag/enable bank
// Assumes: 125 MHz clock, core model answers every vector still presented when its delay runs out
// Notes:   read data is checked from a queue at each read ack
`timescale 1ns/1ps
`default_nettype none
module ifeb_bank_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [3:0]  sel = 4'hF;
    logic [31:0] dat = 32'h0;
    logic [11:0] evt = 12'h000;
    logic [1:0]  dly = 2'h0;
    logic [31:0] rnd, en;
    logic [4:0]  off;
    wire  [31:0] rdat;
    wire         ack, take, cirq, irq;
    wire  [3:0]  src;
    logic [31:0] exp_q[$];
    int          num_errors = 0;
    int          check_count = 0;
    int          i, k;
////////////////////////////////////////////////////////////////////////////////
    ifeb_bank dut_u
    (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .timer_zero_evt_i(evt[0]), .conversion_done_evt_i(evt[1]),
        .comparator_two_evt_i(evt[2]), .comparator_three_evt_i(evt[3]),
        .low_voltage_detector_evt_i(evt[4]), .timer_one_evt_i(evt[5]),
        .timer_two_evt_i(evt[6]), .eeprom_evt_i(evt[7]), .pulse_timer_evt_i(evt[8]),
        .pulse_autocount_evt_i(evt[9]), .pulse_retrigger_evt_i(evt[10]),
        .twowire_evt_i(evt[11]), .core_take_i(take), .core_irq_o(cirq),
        .core_src_o(src), .irq_o(irq)
    );
    ifeb_core_model core_u
    (
        .clk_i(clk_i), .rst_i(rst_i), .irq_i(cirq), .delay_i(dly), .take_o(take)
    );
    // clock and watchdog
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end
    initial
    begin
        #200000;
        num_errors++;
        give_verdict;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ev);
        begin
            check_count++;
            if (seen !== ev)
            begin
                num_errors++;
                $display("mismatch %s expected %h seen %h", nm, ev, seen);
            end
        end
    endtask
    task automatic give_verdict;
        begin
            $display("checks %0d errors %0d", check_count, num_errors);
            if (num_errors == 0 && check_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // classic single wishbone cycle, released at the ack edge
    task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            dat <= d;
            sel <= s;
            @(posedge clk_i);
            while (ack !== 1'b1) @(posedge clk_i);
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        begin
            exp_q.push_back(e);
            wb(a, 1'b0, 32'h0);
        end
    endtask
    task automatic pulse(input int n);
        begin
            @(posedge clk_i);
            evt[n] <= 1'b1;
            @(posedge clk_i);
            evt <= 12'h000;
        end
    endtask
    task automatic wait_irq(input logic v);
        begin
            for (k = 0; k < 40 && cirq !== v; k++) @(posedge clk_i);
            check("core irq", cirq, v);
        end
    endtask
    task automatic cycles(input int n);
        begin
            repeat (n) @(posedge clk_i);
            #1;
        end
    endtask
    // read results against the oldest note
    always @(posedge clk_i)
    begin
        if (ack === 1'b1 && we === 1'b0)
            check("read data", rdat, exp_q.pop_front());
    end
    initial
    begin
        rnd = $urandom(91720);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 7; i++) rd(5'(i * 4), 32'h0);
        for (i = 0; i < 3; i++)
        begin
            rnd = $urandom;
            wb(5'(i * 4), 1'b1, rnd);
            rd(5'(i * 4), {24'h0, rnd[7:0]});
            wb(5'(i * 4), 1'b1, 32'h0);
        end
        wb(5'h00, 1'b1, 32'hFF, 4'hE);
        rd(5'h00, 32'h0);
        for (i = 0; i < 12; i++)
        begin
            off = 5'(i / 4 * 4);
            pulse(i);
            rd(off, 32'h1 << (i % 4 + 4));
            wb(off, 1'b1, 32'h0);
        end
        for (i = 0; i < 12; i++)
        begin
            off = 5'(i / 4 * 4);
            en = 32'h1 << (i % 4);
            dly <= 2'($urandom % 4);
            wb(5'h14, 1'b1, {31'h0, i[0]});
            pulse(i);
            wb(5'h0C, 1'b1, 32'h1);
            cycles(3);
            check("irq enable off", cirq, 1'b0);
            wb(off, 1'b1, en | (en << 4));
            wait_irq(1'b1);
            check("source", src, i);
            wait_irq(1'b0);
            cycles(2);
            check("irq line", irq, i[0]);
            rd(5'h0C, 32'h0);
            rd(off, en);
            pulse(i);
            cycles(3);
            check("irq global off", cirq, 1'b0);
            rd(off, en | (en << 4));
            rd(5'h10, 32'h3);
            wb(off, 1'b1, 32'h0);
            wb(5'h10, 1'b1, 32'h3);
            cycles(2);
            check("irq cleared", irq, 1'b0);
        end
        // global enable cleared by software before the slow core answers
        dly <= 2'h3;
        wb(5'h0C, 1'b1, 32'h1);
        wb(5'h00, 1'b1, 32'h11);
        wb(5'h0C, 1'b1, 32'h0);
        cycles(3);
        check("irq global write", cirq, 1'b0);
        rd(5'h00, 32'h11);
        give_verdict;
    end
endmodule
`default_nettype wire
